// ---- verilog/status_led_output_mux.sv ----
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module status_led_output_mux #(
  parameter int PIN_COUNT = 3
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [31:0] rdata,
  input wire logic controllerOn,
  input wire logic initActive,
  input wire logic [1:0] protoState,
  input wire logic integrationDone,
  input wire logic coldStartAck,
  input wire logic remotePinVoting,
  input wire logic protoActivity,
  input wire logic tcuTick,
  input wire logic tcuOverflow,
  input wire logic actionTime,
  input wire logic txGateActiveCh0,
  input wire logic txGateActiveCh1,
  output logic [2:0] statusPinOut,
  output logic [2:0] statusPinOe
);
  // ****************************************
  // parameter check
  // ****************************************
  if (PIN_COUNT != status_led_pkg::PIN_COUNT) begin : g_bad
    $error("status port has exactly three pins");
  end

  // ****************************************
  // register file
  // ****************************************
  logic [9:0] cfg_r;
  logic portEnable_r;
  logic [31:0] rdata_r;
  logic driving_r;
  logic syncValid_r;

  wire wrCfg = wrStrobe && (addr == status_led_pkg::ADDR_CFG);
  wire wrCtrl = wrStrobe && (addr == status_led_pkg::ADDR_CTRL);
  wire rdCfg = rdStrobe && (addr == status_led_pkg::ADDR_CFG);
  wire rdCtrl = rdStrobe && (addr == status_led_pkg::ADDR_CTRL);
  wire rdStat = rdStrobe && (addr == status_led_pkg::ADDR_STATUS);

  wire [31:0] cfgWord = {22'h000000, cfg_r};
  wire [31:0] ctrlWord = {31'h00000000, portEnable_r};
  wire [31:0] statWord = {24'h000000, statusPinOe, statusPinOut,
                          syncValid_r, driving_r};
  wire [31:0] rdataNxt = rdCfg ? cfgWord :
                         rdCtrl ? ctrlWord :
                         rdStat ? statWord : 32'h00000000;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= status_led_pkg::CFG_RESET;
      portEnable_r <= status_led_pkg::CTRL_RESET;
      rdata_r <= 32'h00000000;
    end else begin
      if (wrCfg) begin
        cfg_r <= wdata[9:0];
      end
      if (wrCtrl) begin
        portEnable_r <= wdata[status_led_pkg::CTRL_EN_BIT];
      end
      rdata_r <= rdataNxt;
    end
  end
  assign rdata = rdata_r;

  // ****************************************
  // configuration fields
  // ****************************************
  wire swapProto = cfg_r[status_led_pkg::CFG_SWAP_BIT];
  wire [2:0] openDrain = cfg_r[status_led_pkg::CFG_OD_LSB +: 3];
  wire [1:0] modeLow = cfg_r[1:0];
  wire [1:0] modeMid = cfg_r[3:2];
  wire [1:0] modeHigh = cfg_r[5:4];

  // ****************************************
  // drive enable and cluster sync
  // ****************************************
  wire startDrive = portEnable_r && controllerOn && initActive;
  wire drivingNxt = startDrive || (driving_r && portEnable_r);
  wire syncFromListen = integrationDone &&
    (protoState == status_led_pkg::PS_LISTENING);
  wire syncFromCold = coldStartAck &&
    (protoState == status_led_pkg::PS_COLD_START);
  wire syncSet = syncFromListen || syncFromCold;
  wire syncValidNxt = syncSet || (syncValid_r && controllerOn);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      driving_r <= 1'b0;
      syncValid_r <= 1'b0;
    end else begin
      driving_r <= drivingNxt;
      syncValid_r <= syncValidNxt;
    end
  end

  // ****************************************
  // source registers
  // ****************************************
  status_src_if #(.PINS(3)) src();

  logic [2:0] proto_r;
  logic [2:0] timing_r;
  logic [2:0] guard_r;

  wire protoLowNxt = swapProto ? remotePinVoting : protoActivity;
  wire protoHighNxt = swapProto ? protoActivity : remotePinVoting;
  wire [2:0] protoNxt = {protoHighNxt, syncValid_r, protoLowNxt};
  wire [2:0] timingNxt = {tcuOverflow, tcuTick, 1'b0};
  wire [2:0] guardNxt = {actionTime, txGateActiveCh1, txGateActiveCh0};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      proto_r <= 3'h0;
      timing_r <= 3'h0;
      guard_r <= 3'h0;
    end else begin
      proto_r <= protoNxt;
      timing_r <= timingNxt;
      guard_r <= guardNxt;
    end
  end
  assign src.protoLevel = proto_r;
  assign src.timingLevel = timing_r;
  assign src.guardLevel = guard_r;

  // ****************************************
  // per pin selection and drivers
  // ****************************************
  wire [5:0] modeAll = cfg_r[5:0];
  for (genvar i = 0; i < 3; i++) begin : g_pin
    logic level;
    logic microSel;
    status_pin_select #(.PIN_INDEX(i)) u_sel (
      .src(src.sink),
      .mode(modeAll[2*i +: 2]),
      .level(level),
      .microSel(microSel)
    );
    status_pin_driver u_drv (
      .clk(clk),
      .rst_b(rst_b),
      .level(level),
      .microSel(microSel),
      .openDrain(openDrain[i]),
      .enable(driving_r),
      .pinOut(statusPinOut[i]),
      .pinOe(statusPinOe[i])
    );
  end

  // ****************************************
  // checking helpers
  // ****************************************
  logic [9:0] cfgD1_r;
  logic [9:0] cfgD2_r;
  logic drvD1_r;
  logic drvD2_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfgD1_r <= status_led_pkg::CFG_RESET;
      cfgD2_r <= status_led_pkg::CFG_RESET;
      drvD1_r <= 1'b0;
      drvD2_r <= 1'b0;
    end else begin
      cfgD1_r <= cfg_r;
      cfgD2_r <= cfgD1_r;
      drvD1_r <= driving_r;
      drvD2_r <= drvD1_r;
    end
  end
  wire steady = (cfg_r == cfgD1_r) && (cfgD1_r == cfgD2_r) &&
                drvD1_r && drvD2_r;
  wire ppHigh = steady && !openDrain[status_led_pkg::PIN_HIGH];
  wire ppMid = steady && !openDrain[status_led_pkg::PIN_MID];
  wire ppLow = steady && !openDrain[status_led_pkg::PIN_LOW];

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_listening_state_sync;
    syncFromListen;
  endsequence
  sequence s_cold_sync;
    syncFromCold;
  endsequence
  sequence s_sync_shown;
    ##2 (statusPinOut[status_led_pkg::PIN_MID] == 1'b1);
  endsequence

  AST_UNDRIVEN: assert property (
    !drvD1_r |-> (statusPinOe == 3'h0))
    else $error("status pin driven before initialization");

  AST_DRIVE_START: assert property (
    startDrive |=> driving_r ##1 (statusPinOe[status_led_pkg::PIN_MID]
      || openDrain[status_led_pkg::PIN_MID]))
    else $error("status port not driven after initialization");

  AST_SYNC: assert property (
    (s_listening_state_sync or s_cold_sync) ##0
      (ppMid && modeMid == status_led_pkg::MODE_PROTOCOL && controllerOn)
      |=> syncValid_r ##0 s_sync_shown)
    else $error("cluster sync not shown on mid pin");

  AST_OVERFLOW: assert property (
    (ppHigh && modeHigh == status_led_pkg::MODE_TIMING) |->
      (statusPinOut[status_led_pkg::PIN_HIGH] == $past(tcuOverflow, 2)))
    else $error("overflow pulse wrong on high pin");

  AST_TICK: assert property (
    (ppMid && modeMid == status_led_pkg::MODE_TIMING) |->
      (statusPinOut[status_led_pkg::PIN_MID] == $past(tcuTick, 2)))
    else $error("tick pulse wrong on mid pin");

  AST_MICRO_OE: assert property (
    (ppLow && modeLow == status_led_pkg::MODE_TIMING) |->
      statusPinOe[status_led_pkg::PIN_LOW])
    else $error("microtick pin not driven");

  AST_ACTION: assert property (
    (ppHigh && modeHigh == status_led_pkg::MODE_GUARDIAN) |->
      (statusPinOut[status_led_pkg::PIN_HIGH] == $past(actionTime, 2)))
    else $error("action time wrong on high pin");

  AST_GATE: assert property (
    (ppLow && ppMid && modeLow == status_led_pkg::MODE_GUARDIAN &&
      modeMid == status_led_pkg::MODE_GUARDIAN) |->
      (statusPinOut[status_led_pkg::PIN_LOW] == $past(txGateActiveCh0, 2))
      && (statusPinOut[status_led_pkg::PIN_MID] ==
        $past(txGateActiveCh1, 2)))
    else $error("gate activity wrong on low or mid pin");

  AST_PROTO_DEFAULT: assert property (
    (ppHigh && !swapProto && modeHigh == status_led_pkg::MODE_PROTOCOL)
      |-> (statusPinOut[status_led_pkg::PIN_HIGH] ==
        $past(remotePinVoting, 2)))
    else $error("voting signal missing on high pin");

  AST_SWAP: assert property (
    (ppLow && swapProto && modeLow == status_led_pkg::MODE_PROTOCOL)
      |-> (statusPinOut[status_led_pkg::PIN_LOW] ==
        $past(remotePinVoting, 2)))
    else $error("voting signal not swapped to low pin");

  AST_OPEN_DRAIN: assert property (
    (steady && openDrain[status_led_pkg::PIN_HIGH]) |->
      (statusPinOut[status_led_pkg::PIN_HIGH] == 1'b0) &&
      (statusPinOe[status_led_pkg::PIN_HIGH] == !$past(
        modeHigh == status_led_pkg::MODE_TIMING ? tcuOverflow :
        modeHigh == status_led_pkg::MODE_GUARDIAN ? actionTime :
        (swapProto ? protoActivity : remotePinVoting), 2)))
    else $error("open-drain pin drove high");

  AST_REGISTERED: assert property (
    (ppMid && $changed(tcuTick) &&
      modeMid == status_led_pkg::MODE_TIMING) |->
      (statusPinOut[status_led_pkg::PIN_MID] == $past(tcuTick, 2)) ##1
      (statusPinOut[status_led_pkg::PIN_MID] == $past(tcuTick, 2)))
    else $error("mid pin not registered");

  // ****************************************
  // register and drive control checks
  // ****************************************
  AST_CFG_WRITE: assert property (
    wrCfg |=> (cfg_r == $past(wdata[9:0])))
    else $error("configuration write lost");

  AST_CTRL_WRITE: assert property (
    wrCtrl |=> (portEnable_r == $past(wdata[status_led_pkg::CTRL_EN_BIT])))
    else $error("port enable write lost");

  AST_CTRL_READ: assert property (
    (rdStrobe && addr == status_led_pkg::ADDR_CTRL) |=>
      (rdata == {31'h00000000, $past(portEnable_r)}))
    else $error("control read data wrong");

  AST_RDATA_IDLE: assert property (
    !$past(rdStrobe) |-> (rdata == 32'h00000000))
    else $error("read data not cleared outside a read");

  AST_DRIVE_HOLD: assert property (
    (driving_r && portEnable_r) |=> driving_r)
    else $error("status port stopped while enabled");

  AST_DRIVE_STOP: assert property (
    !portEnable_r |=> !driving_r)
    else $error("status port driven while disabled");

  AST_SYNC_HOLD: assert property (
    (syncValid_r && controllerOn) |=> syncValid_r)
    else $error("cluster sync lost while controller on");

  AST_SYNC_CLEAR: assert property (
    (!controllerOn && !syncSet) |=> !syncValid_r)
    else $error("cluster sync kept while controller off");

  AST_OD_LOW_PIN: assert property (
    $past(openDrain[status_led_pkg::PIN_LOW]) |->
      !statusPinOut[status_led_pkg::PIN_LOW])
    else $error("open-drain low pin drove high");

  AST_OD_MID_PIN: assert property (
    $past(openDrain[status_led_pkg::PIN_MID]) |->
      !statusPinOut[status_led_pkg::PIN_MID])
    else $error("open-drain mid pin drove high");

  AST_PROTO_ACTIVITY: assert property (
    (ppLow && !swapProto && modeLow == status_led_pkg::MODE_PROTOCOL)
      |-> (statusPinOut[status_led_pkg::PIN_LOW] ==
        $past(protoActivity, 2)))
    else $error("activity signal missing on low pin");

  AST_SWAP_ACTIVITY: assert property (
    (ppHigh && swapProto && modeHigh == status_led_pkg::MODE_PROTOCOL)
      |-> (statusPinOut[status_led_pkg::PIN_HIGH] ==
        $past(protoActivity, 2)))
    else $error("activity signal not swapped to high pin");
endmodule
`default_nettype wire

// ---- verilog/status_led_pkg.sv ----
`default_nettype none
package status_led_pkg;
  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam int CFG_WIDTH = 10;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_MODE_WIDTH = 2;
  localparam int CFG_SWAP_BIT = 6;
  localparam int CFG_OD_LSB = 7;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_DRIVING_BIT = 0;
  localparam int STAT_SYNC_BIT = 1;
  localparam int STAT_OUT_LSB = 2;
  localparam int STAT_OE_LSB = 5;
  localparam logic [9:0] CFG_RESET = 10'h000;
  localparam logic CTRL_RESET = 1'b0;
  // ****************************************
  // pins and pipeline
  // ****************************************
  localparam int PIN_COUNT = 3;
  localparam int PIN_LOW = 0;
  localparam int PIN_MID = 1;
  localparam int PIN_HIGH = 2;
  localparam int PIPE_LATENCY = 2;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_PROTOCOL = 2'b00,
    MODE_TIMING = 2'b01,
    MODE_GUARDIAN = 2'b10
  } pin_mode_t;
  typedef enum logic [1:0] {
    PS_OTHER = 2'b00,
    PS_LISTENING = 2'b01,
    PS_COLD_START = 2'b10
  } proto_state_t;
endpackage
`default_nettype wire

// ---- verilog/status_src_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface status_src_if #(parameter int PINS = 3);
  // ****************************************
  // registered candidate levels per pin
  // ****************************************
  logic [PINS-1:0] protoLevel;
  logic [PINS-1:0] timingLevel;
  logic [PINS-1:0] guardLevel;
  modport source (output protoLevel, output timingLevel, output guardLevel);
  modport sink (input protoLevel, input timingLevel, input guardLevel);
endinterface
`default_nettype wire

// ---- verilog/status_pin_select.sv ----
`timescale 1ns/10ps
`default_nettype none
module status_pin_select #(
  parameter int PIN_INDEX = 0
) (
  status_src_if.sink src,
  input wire logic [1:0] mode,
  output logic level,
  output logic microSel
);
  // ****************************************
  // per pin source selection
  // ****************************************
  wire isTiming = (mode == status_led_pkg::MODE_TIMING);
  wire isGuard = (mode == status_led_pkg::MODE_GUARDIAN);
  assign level = isTiming ? src.timingLevel[PIN_INDEX] :
                 isGuard ? src.guardLevel[PIN_INDEX] :
                 src.protoLevel[PIN_INDEX];
  // microtick: main clock on the lowest pin
  assign microSel = isTiming && (PIN_INDEX == status_led_pkg::PIN_LOW);
endmodule
`default_nettype wire

// ---- verilog/status_pin_driver.sv ----
`timescale 1ns/10ps
`default_nettype none
module status_pin_driver (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic level,
  input wire logic microSel,
  input wire logic openDrain,
  input wire logic enable,
  output logic pinOut,
  output logic pinOe
);
  logic out_r;
  logic oe_r;
  logic micro_r;
  logic od_r;
  logic en_r;
  logic tglPos_r;
  logic tglNeg_r;
  // ****************************************
  // output stage
  // ****************************************
  wire outNxt = openDrain ? 1'b0 : level;
  wire oeNxt = enable && (!openDrain || !level);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_r <= 1'b0;
      oe_r <= 1'b0;
      micro_r <= 1'b0;
      od_r <= 1'b0;
      en_r <= 1'b0;
      tglPos_r <= 1'b0;
    end else begin
      out_r <= outNxt;
      oe_r <= oeNxt;
      micro_r <= microSel;
      od_r <= openDrain;
      en_r <= enable;
      tglPos_r <= !tglPos_r;
    end
  end
  // ****************************************
  // clock replica, high in first half cycle
  // ****************************************
  always_ff @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tglNeg_r <= 1'b0;
    end else begin
      tglNeg_r <= tglPos_r;
    end
  end
  wire clkCopy = tglPos_r ^ tglNeg_r;
  assign pinOut = micro_r ? (!od_r && clkCopy) : out_r;
  assign pinOe = micro_r ? (en_r && (!od_r || !clkCopy)) : oe_r;
endmodule
`default_nettype wire

// ---- verification/status_led_sink.sv ----
`timescale 1ns/10ps
`default_nettype none
module status_led_sink (
  input wire logic clk,
  input wire logic [2:0] pinOut,
  input wire logic [2:0] pinOe,
  output logic [2:0] level,
  output var int midCount,
  output var int highCount
);
  // ****************************************
  // pin levels, weak pull-down when undriven
  // ****************************************
  assign level = pinOe & pinOut;
  // ****************************************
  // time base clone: count high cycles
  // ****************************************
  initial begin
    midCount = 0;
    highCount = 0;
  end
  always @(posedge clk) begin
    if (level[1] === 1'b1) midCount <= midCount + 1;
    if (level[2] === 1'b1) highCount <= highCount + 1;
  end
endmodule
`default_nettype wire

// ---- verification/tb_status_led_output_mux.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_status_led_output_mux;
  logic clk, rst_b, wrStrobe, rdStrobe, controllerOn, initActive;
  logic integrationDone, coldStartAck, remotePinVoting, protoActivity;
  logic tcuTick, tcuOverflow, actionTime, txGateActiveCh0, txGateActiveCh1;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic [1:0] protoState;
  logic [2:0] statusPinOut, statusPinOe, level;
  logic swap, expSync;
  int midCount, highCount, err_count, cmp_count, seed, m0, h0, em, eh, i, k;
  status_led_output_mux dut_u (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdata(rdata),
    .controllerOn(controllerOn), .initActive(initActive),
    .protoState(protoState), .integrationDone(integrationDone),
    .coldStartAck(coldStartAck), .remotePinVoting(remotePinVoting),
    .protoActivity(protoActivity), .tcuTick(tcuTick),
    .tcuOverflow(tcuOverflow), .actionTime(actionTime),
    .txGateActiveCh0(txGateActiveCh0), .txGateActiveCh1(txGateActiveCh1),
    .statusPinOut(statusPinOut), .statusPinOe(statusPinOe));
  status_led_sink sink_u (.clk(clk), .pinOut(statusPinOut),
    .pinOe(statusPinOe), .level(level), .midCount(midCount),
    .highCount(highCount));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic print_verdict;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", n, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask
  task automatic rd(string n, logic [3:0] a, logic [31:0] e, logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    @(negedge clk);
    chk(n, e, rdata & m);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulseIn(logic ack);
    @(posedge clk);
    if (ack) coldStartAck <= 1'b1;
    else integrationDone <= 1'b1;
    @(posedge clk);
    coldStartAck <= 1'b0;
    integrationDone <= 1'b0;
    settle;
  endtask
  task automatic pulseRun(logic guard);
    @(posedge clk);
    {txGateActiveCh1, txGateActiveCh0} <= 2'h0;
    settle;
    m0 = midCount;
    h0 = highCount;
    em = 0;
    eh = 0;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      k = $random(seed);
      tcuTick <= k[0] & !guard;
      tcuOverflow <= k[0] & k[1] & !guard;
      actionTime <= k[2] & guard;
      em += k[0] & !guard;
      eh += guard ? k[2] : k[0] & k[1];
    end
    @(posedge clk);
    {tcuTick, tcuOverflow, actionTime} <= 3'h0;
    settle;
    chk("midPulses", em, midCount - m0);
    chk("highPulses", eh, highCount - h0);
  endtask
  // ****************************************
  // clock and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #5000000;
    err_count++;
    print_verdict;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst_b, wrStrobe, rdStrobe, controllerOn, initActive} = 5'h00;
    {integrationDone, coldStartAck, remotePinVoting, protoActivity} = 4'h0;
    {tcuTick, tcuOverflow, actionTime, txGateActiveCh0} = 4'h0;
    {txGateActiveCh1, protoState, addr, wdata} = '0;
    {swap, expSync, err_count, cmp_count} = '0;
    seed = 94165;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("oeReset", 0, statusPinOe);
    chk("levelReset", 0, level);
    rd("cfgReset", 4'h0, 32'h0, 32'h3FF);
    rd("ctrlReset", 4'h4, 32'h0, 32'h1);
    rd("unmapped", 4'hC, 32'h0, 32'hFFFFFFFF);
    wr(4'h4, 32'h1);
    settle;
    chk("oeNoHost", 0, statusPinOe);
    @(posedge clk);
    controllerOn <= 1'b1;
    initActive <= 1'b1;
    for (i = 0; i < 10 && statusPinOe !== 3'h7; i++) @(negedge clk);
    chk("oeStart", 3'h7, statusPinOe);
    if (i == 10) print_verdict;
    for (k = 0; k < 18; k++) begin
      if (k % 6 == 0) begin
        swap = (k / 6 == 2);
        wr(4'h0, {25'h0, swap, (k < 6) ? 6'h3F : 6'h00});
      end
      @(posedge clk);
      {remotePinVoting, protoActivity} <= 2'($random(seed));
      settle;
      chk("protoPins", {swap ? protoActivity : remotePinVoting, expSync,
        swap ? remotePinVoting : protoActivity}, statusPinOut);
    end
    pulseIn(1'b0);
    chk("syncOther", 0, statusPinOut[1]);
    @(posedge clk);
    protoState <= status_led_pkg::PS_LISTENING;
    pulseIn(1'b0);
    chk("syncListen", 1, statusPinOut[1]);
    rd("statusSync", 4'h8, 32'h3, 32'h3);
    @(posedge clk);
    controllerOn <= 1'b0;
    settle;
    chk("syncCleared", 0, statusPinOut[1]);
    @(posedge clk);
    controllerOn <= 1'b1;
    protoState <= status_led_pkg::PS_COLD_START;
    pulseIn(1'b1);
    chk("syncCold", 1, statusPinOut[1]);
    wr(4'h0, 32'h15);
    pulseRun(1'b0);
    @(posedge clk);
    #25;
    chk("microHigh", 1, statusPinOut[0]);
    #50;
    chk("microLow", 0, statusPinOut[0]);
    chk("microOe", 1, statusPinOe[0]);
    wr(4'h0, 32'h2A);
    for (k = 0; k < 6; k++) begin
      @(posedge clk);
      {txGateActiveCh1, txGateActiveCh0} <= 2'($random(seed));
      settle;
      chk("gatePins", {1'b0, txGateActiveCh1, txGateActiveCh0},
        statusPinOut);
    end
    pulseRun(1'b1);
    wr(4'h0, 32'h3AA);
    @(posedge clk);
    {txGateActiveCh1, txGateActiveCh0} <= 2'h1;
    settle;
    chk("odOut", 0, statusPinOut);
    chk("odOe", 3'h6, statusPinOe);
    wr(4'h4, 32'h0);
    settle;
    chk("oeDisabled", 0, statusPinOe);
    wr(4'h4, 32'h1);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk("oeMidReset", 0, statusPinOe);
    rst_b <= 1'b1;
    rd("cfgAfterReset", 4'h0, 32'h0, 32'h3FF);
    chk("oeAfterReset", 0, statusPinOe);
    print_verdict;
  end
endmodule
`default_nettype wire
